// *** hdl/amp_prot_consts.vh ***
// constants for the class-d supervision and modulation block
`ifndef AMP_PROT_CONSTS_VH
`define AMP_PROT_CONSTS_VH
// axi4-lite register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_EN 8'h0C
`define REG_IRQ_CLR 8'h10
`define REG_DUTY 8'h14
// ctrl fields
`define CTRL_RESET 32'h0000_0000
// irq bit positions
`define IRQ_OC 0
`define IRQ_OT 1
`define IRQ_DC 2
`define IRQ_UV 3
`define IRQ_OV 4
`define IRQ_W 5
// timing
`define CLK_HZ 50000000
`define DC_TIME_MS 420
`define STARTUP_TIME_MS 10
`define DC_CYCLES ((`CLK_HZ / 1000) * `DC_TIME_MS)
`define STARTUP_CYCLES ((`CLK_HZ / 1000) * `STARTUP_TIME_MS)
// modulation
`define PWM_PERIOD 8'hFF
`define DUTY_HALF 8'h80
`define DC_DUTY_HI 8'h99
`define DC_DUTY_LO 8'h66
`define SSPW_IDLE 8'h26
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** hdl/amp_fault_protection_modulation.v ***
// supervision, fault latching and pwm modulation for a stereo class-d stage
// Contract
// - over-current latches fault, flag low, outputs hi-z
// - over-temperature latches fault, shutdown, flag low
// - dc-detect latches fault, flag low, hi-z
// - undervoltage hi-z without flag, self-clearing
// - overvoltage hi-z without flag, self-clearing
// - duty over 60% same polarity 420ms faults; in single-side mode the code trips at a duty over about 20%
// - latched faults clear only through shutdown low
// - grounded left inputs at power-up select mono
// - select pin low dual-edge, high single-side
// - dual-edge halves swing rail, in phase idle
// - positive signal: pos half above, neg below
// - single-side mode idles at about 15%
// - single-side falling half rails to ground
// - start-up lasts 10 ms before amplification
// - shutdown low mutes, low-current; high operates
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "amp_prot_consts.vh"

module amp_fault_protection_modulation #(
    parameter DC_CYCLES = `DC_CYCLES,
    parameter STARTUP_CYCLES = `STARTUP_CYCLES
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // analog comparator indications and pins (asynchronous)
    input wire over_current_in,
    input wire over_temp_in,
    input wire supply_under_in,
    input wire supply_over_in,
    input wire shutdown_in_low,
    input wire modulation_select_pin,
    input wire left_input_plus_gnd,
    input wire left_input_minus_gnd,
    input wire mute_in,
    // audio sample per channel, signed, from loop filter logic
    input wire [7:0] audio_left,
    input wire [7:0] audio_right,
    // power stage
    output reg [1:0] out_pos_half,
    output reg [1:0] out_neg_half,
    output reg [1:0] out_drive_en,
    output reg fault_flag_out,
    output reg low_current_out,
    output wire irq,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam ST_OFF = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_RUN = 2'h2;
    localparam ST_FAULT = 2'h3;
    localparam NSYNC = 9;

    // two-flop synchronisers for all pin inputs
    wire [NSYNC-1:0] pins_raw = {mute_in, left_input_minus_gnd, left_input_plus_gnd,
        modulation_select_pin, shutdown_in_low, supply_over_in, supply_under_in,
        over_temp_in, over_current_in};
    reg [NSYNC-1:0] sync1_q;
    reg [NSYNC-1:0] sync2_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= {NSYNC{1'b0}};
            sync2_q <= {NSYNC{1'b0}};
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end
    wire oc_s = sync2_q[0];
    wire ot_s = sync2_q[1];
    wire uv_s = sync2_q[2];
    wire ov_s = sync2_q[3];
    wire sd_low_s = ~sync2_q[4];
    wire modulation_select_pin_s = sync2_q[5];
    wire left_gnd_s = sync2_q[6] & sync2_q[7];
    wire mute_s = sync2_q[8];

    reg [1:0] state_q;
    reg [31:0] start_cnt_q;
    reg [2:0] latch_q;
    reg mono_q;
    reg strap_done_q;
    reg [31:0] dc_cnt_q [0:1];
    reg [1:0] dc_pol_q;
    reg [7:0] pwm_cnt_q;
    reg [31:0] ctrl_q;
    reg [`IRQ_W-1:0] irq_stat_q;
    reg [`IRQ_W-1:0] irq_en_q;

    wire soft_mute = ctrl_q[0];
    wire self_clear = uv_s | ov_s;
    wire dc_hit = (dc_cnt_q[0] > DC_CYCLES) | (dc_cnt_q[1] > DC_CYCLES);
    wire [2:0] new_fault = {dc_hit, ot_s, oc_s};

    // mono strap caught once after reset release, never under reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            mono_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q && state_q == ST_START) begin
            mono_q <= left_gnd_s;
            strap_done_q <= 1'b1;
        end
    end

    // latched faults; an over-current or over-temperature fault present while shutdown is low stays set, dc-detect clears
    always @(posedge aclk) begin
        if (!aresetn)
            latch_q <= 3'h0;
        else if (sd_low_s)
            latch_q <= new_fault & {1'b0, ot_s, oc_s};
        else
            latch_q <= latch_q | new_fault;
    end

    // operating state
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_OFF;
            start_cnt_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                ST_OFF: begin
                    start_cnt_q <= 32'h0000_0000;
                    if (!sd_low_s && latch_q == 3'h0)
                        state_q <= ST_START;
                end
                ST_START: begin
                    start_cnt_q <= start_cnt_q + 32'h0000_0001;
                    if (sd_low_s)
                        state_q <= ST_OFF;
                    else if (latch_q != 3'h0 || new_fault != 3'h0)
                        state_q <= ST_FAULT;
                    else if (start_cnt_q >= STARTUP_CYCLES - 1)
                        state_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (sd_low_s)
                        state_q <= ST_OFF;
                    else if (latch_q != 3'h0 || new_fault != 3'h0)
                        state_q <= ST_FAULT;
                end
                default: begin
                    // leave only through shutdown, then full start-up again
                    if (sd_low_s)
                        state_q <= ST_OFF;
                end
            endcase
        end
    end

    // pwm carrier
    always @(posedge aclk) begin
        if (!aresetn)
            pwm_cnt_q <= 8'h00;
        else
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end

    // duty of each half per channel; mono drives both from the right input
    reg [7:0] duty_p [0:1];
    reg [7:0] duty_n [0:1];
    integer ch;
    reg [7:0] smp;
    reg [7:0] mag;
    always @* begin
        smp = 8'h00;
        mag = 8'h00;
        for (ch = 0; ch < 2; ch = ch + 1) begin
            smp = (ch == 0 && !mono_q) ? audio_left : audio_right;
            mag = smp[7] ? (~smp + 8'h01) : smp;
            if (!modulation_select_pin_s) begin
                duty_p[ch] = `DUTY_HALF + smp;
                duty_n[ch] = `DUTY_HALF - smp;
            end else if (smp[7]) begin
                duty_p[ch] = 8'h00;
                duty_n[ch] = `SSPW_IDLE + mag;
            end else if (smp != 8'h00) begin
                duty_p[ch] = `SSPW_IDLE + mag;
                duty_n[ch] = 8'h00;
            end else begin
                duty_p[ch] = `SSPW_IDLE;
                duty_n[ch] = `SSPW_IDLE;
            end
        end
    end

    // board mute only holds the stage off; it raises no flag
    wire run_ok = (state_q == ST_RUN) && !self_clear && !soft_mute && !mute_s;

    // outputs and dc detector per channel
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            wire pos_big = duty_p[g] > duty_n[g] &&
                (duty_p[g] - duty_n[g]) > (`DC_DUTY_HI - `DC_DUTY_LO);
            wire neg_big = duty_n[g] > duty_p[g] &&
                (duty_n[g] - duty_p[g]) > (`DC_DUTY_HI - `DC_DUTY_LO);
            always @(posedge aclk) begin
                if (!aresetn) begin
                    out_pos_half[g] <= 1'b0;
                    out_neg_half[g] <= 1'b0;
                    out_drive_en[g] <= 1'b0;
                    dc_cnt_q[g] <= 32'h0000_0000;
                    dc_pol_q[g] <= 1'b0;
                end else begin
                    out_pos_half[g] <= run_ok && (pwm_cnt_q < duty_p[g]);
                    out_neg_half[g] <= run_ok && (pwm_cnt_q < duty_n[g]);
                    out_drive_en[g] <= run_ok;
                    if (!run_ok || !(pos_big || neg_big) || dc_pol_q[g] != pos_big)
                        dc_cnt_q[g] <= 32'h0000_0000;
                    else if (dc_cnt_q[g] <= DC_CYCLES)
                        dc_cnt_q[g] <= dc_cnt_q[g] + 32'h0000_0001;
                    dc_pol_q[g] <= pos_big;
                end
            end
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            fault_flag_out <= 1'b1;
            low_current_out <= 1'b1;
        end else begin
            fault_flag_out <= ~((latch_q | new_fault) != 3'h0);
            low_current_out <= sd_low_s;
        end
    end

    // interrupt status: set wins over clear
    wire [`IRQ_W-1:0] events = {ov_s, uv_s, latch_q};
    reg aw_held_q;
    reg w_held_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    wire wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
    wire clr_hit = wr_go && awaddr_q == `REG_IRQ_CLR;
    always @(posedge aclk) begin
        if (!aresetn)
            irq_stat_q <= 5'h00;
        else
            irq_stat_q <= (irq_stat_q & ~(clr_hit ? wdata_q[`IRQ_W-1:0] : 5'h00)) | events;
    end
    assign irq = (irq_stat_q & irq_en_q) != 5'h00;

    // axi4-lite write path
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready = !w_held_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            ctrl_q <= `CTRL_RESET;
            irq_en_q <= 5'h00;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                // byte strobes ignored on every register; full word expected
                if (awaddr_q == `REG_CTRL)
                    ctrl_q <= wdata_q;
                else if (awaddr_q == `REG_IRQ_EN)
                    irq_en_q <= wdata_q[`IRQ_W-1:0];
                else if (awaddr_q != `REG_IRQ_CLR)
                    s_axi_bresp <= `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // axi4-lite read path
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            if (s_axi_araddr == `REG_CTRL)
                s_axi_rdata <= ctrl_q;
            else if (s_axi_araddr == `REG_STATUS)
                s_axi_rdata <= {24'h000000, mono_q, modulation_select_pin_s, latch_q, state_q, fault_flag_out};
            else if (s_axi_araddr == `REG_IRQ_STAT)
                s_axi_rdata <= {27'h0000000, irq_stat_q};
            else if (s_axi_araddr == `REG_IRQ_EN)
                s_axi_rdata <= {27'h0000000, irq_en_q};
            else if (s_axi_araddr == `REG_IRQ_CLR)
                s_axi_rdata <= 32'h0000_0000;
            else if (s_axi_araddr == `REG_DUTY)
                s_axi_rdata <= {duty_n[1], duty_p[1], duty_n[0], duty_p[0]};
            else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule // amp_fault_protection_modulation
`default_nettype wire

// *** bench/amp_prot_checker.sv ***
// assertion checker for the class-d supervision block
`timescale 1ns/1ps
`default_nettype none
module amp_prot_checker #(
    parameter STARTUP_CYCLES = 20
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // pins
    input wire over_current_in,
    input wire over_temp_in,
    input wire supply_under_in,
    input wire supply_over_in,
    input wire shutdown_in_low,
    // power stage
    input wire [1:0] out_drive_en,
    input wire fault_flag_out,
    input wire low_current_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles since shutdown was released, saturating so it never wraps
    reg [31:0] up_q;
    always @(posedge aclk) begin
        if (!aresetn || !shutdown_in_low)
            up_q <= 32'h0;
        else if (up_q < STARTUP_CYCLES + 8)
            up_q <= up_q + 32'h1;
    end
    AST_START: assert property ($rose(out_drive_en[0]) |-> up_q >= STARTUP_CYCLES)
        else $error("outputs enabled before start-up time");
    AST_OC: assert property ($rose(over_current_in) && up_q > 6 |-> ##[1:6] !fault_flag_out)
        else $error("over-current did not lower the fault flag");
    AST_OT: assert property ($rose(over_temp_in) && up_q > 6 |-> ##[1:6] !fault_flag_out)
        else $error("over-temperature did not lower the fault flag");
    AST_HIZ: assert property (!fault_flag_out [*3] |-> out_drive_en == 2'b00)
        else $error("outputs driven during a fault");
    AST_UV: assert property (supply_under_in [*6] |-> out_drive_en == 2'b00)
        else $error("outputs driven at low supply");
    AST_OV: assert property (supply_over_in [*6] |-> out_drive_en == 2'b00)
        else $error("outputs driven at high supply");
    AST_SD: assert property (!shutdown_in_low [*6] |-> low_current_out && out_drive_en == 2'b00)
        else $error("shutdown did not mute the stage");
    AST_LATCH: assert property (!fault_flag_out && up_q > 6 |=> !fault_flag_out)
        else $error("latched fault cleared without shutdown");
endmodule // amp_prot_checker
bind amp_fault_protection_modulation amp_prot_checker #(
    .STARTUP_CYCLES(STARTUP_CYCLES)
) i_chk (
    .aclk(aclk), .aresetn(aresetn), .over_current_in(over_current_in),
    .over_temp_in(over_temp_in), .supply_under_in(supply_under_in),
    .supply_over_in(supply_over_in), .shutdown_in_low(shutdown_in_low),
    .out_drive_en(out_drive_en), .fault_flag_out(fault_flag_out),
    .low_current_out(low_current_out)
);
`default_nettype wire

// *** bench/sys_ctrl_model.sv ***
// system controller model: drives shutdown and watches the fault flag
`timescale 1ns/1ps
`default_nettype none
module sys_ctrl_model (
    // bench control
    input wire logic auto_mode,
    input wire logic manual_run,
    // device pins
    input wire logic fault_flag_out,
    output logic shutdown_in_low,
    output logic mute_in
);
    // inverted flag keeps the stage muted, so a restart after a hard short begins hi-z
    assign mute_in = ~fault_flag_out;
    // loop-back lets a fault clear its own latch; manual_run starts low
    assign shutdown_in_low = auto_mode ? fault_flag_out : manual_run;
endmodule // sys_ctrl_model
`default_nettype wire

// *** bench/amp_fault_protection_modulation_test.sv ***
// self-checking bench for the class-d supervision block
`timescale 1ns/1ps
`default_nettype none
`include "amp_prot_consts.vh"
module amp_fault_protection_modulation_test;
    logic aclk, aresetn, oc, ot, uv, ov, ms, lp, lm, sd_auto, sd_run;
    logic [7:0] al, ar8, awa, ara;
    logic [31:0] wd, d;
    logic awv, wv, bre, arv, rre;
    wire awr, wrd, bv, arr, rv, irq, fault_flag_out, low_current_out, sdn, mute;
    wire [1:0] br, rrsp, out_pos_half, out_neg_half, out_drive_en;
    wire [31:0] rdat;
    logic [1:0] r;
    int error_cnt, num_checks, i, p, n;
    amp_fault_protection_modulation #(.DC_CYCLES(50), .STARTUP_CYCLES(20)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .over_current_in(oc), .over_temp_in(ot),
        .supply_under_in(uv), .supply_over_in(ov), .shutdown_in_low(sdn),
        .modulation_select_pin(ms), .left_input_plus_gnd(lp), .left_input_minus_gnd(lm),
        .mute_in(mute),
        .audio_left(al), .audio_right(ar8), .out_pos_half(out_pos_half),
        .out_neg_half(out_neg_half), .out_drive_en(out_drive_en),
        .fault_flag_out(fault_flag_out), .low_current_out(low_current_out), .irq(irq),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rv),
        .s_axi_rready(rre));
    sys_ctrl_model i_ctrl (.auto_mode(sd_auto), .manual_run(sd_run),
        .fault_flag_out(fault_flag_out), .shutdown_in_low(sdn), .mute_in(mute));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input [31:0] got, input [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge aclk);
    endtask
    // handshake seen at the negedge holds for the following rising edge
    task automatic wr(input [7:0] a, input [31:0] v, output [1:0] rs);
        logic ta, tw, tb;
        @(posedge aclk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awr;
            tw = wrd;
            tb = bv;
            rs = br;
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tb);
        bre <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, output [31:0] v, output [1:0] rs);
        logic ta, tv;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arr;
            tv = rv;
            v = rdat;
            rs = rrsp;
            @(posedge aclk);
            if (ta) arv <= 1'b0;
        end while (!tv);
        rre <= 1'b0;
    endtask
    task automatic wait_on(input [1:0] v);
        int k;
        k = 0;
        while (out_drive_en !== v && k < 200) begin
            @(negedge aclk);
            k++;
        end
    endtask
    // high cycles of the left halves over one pwm period
    task automatic duty(input [7:0] s);
        @(posedge aclk);
        al <= s;
        cyc(260);
        p = 0;
        n = 0;
        repeat (256) begin
            @(negedge aclk);
            p += out_pos_half[0];
            n += out_neg_half[0];
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        {aresetn, oc, ot, uv, ov, ms, lp, lm, sd_auto, sd_run, al, ar8} = '0;
        {awa, ara, wd, awv, wv, bre, arv, rre} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(2);
        chk(fault_flag_out, 1);
        chk(low_current_out, 1);
        rd(8'h20, d, r);
        chk(r, `RESP_SLVERR);
        wr(`REG_IRQ_EN, 32'h7, r);
        chk(r, `RESP_OKAY);
        @(posedge aclk);
        sd_run <= 1'b1;
        wait_on(2'b11);
        chk(out_drive_en, 2'b11);
        chk(low_current_out, 0);
        $display("startup test done");
        duty(8'h00);
        chk({p > 128, n > 128, p == n}, 3'b001);
        duty(8'h10);
        chk({p > 128, n > 128, p == n}, 3'b100);
        rd(`REG_DUTY, d, r);
        chk(d, 32'h8080_7090);
        duty(8'hF0);
        chk({p > 128, n > 128, p == n}, 3'b010);
        @(posedge aclk);
        ms <= 1'b1;
        duty(8'h00);
        chk(p > 25 && p < 52, 1);
        duty(8'h04);
        chk(n, 0);
        chk(p > 38, 1);
        @(posedge aclk);
        ms <= 1'b0;
        al <= 8'h00;
        $display("modulation test done");
        for (i = 0; i < 2; i++) begin
            @(posedge aclk);
            uv <= (i == 0);
            ov <= (i == 1);
            cyc(8);
            chk(out_drive_en, 0);
            chk(fault_flag_out, 1);
            @(posedge aclk);
            uv <= 1'b0;
            ov <= 1'b0;
            wait_on(2'b11);
            chk(out_drive_en, 2'b11);
        end
        $display("supply test done");
        wr(`REG_CTRL, 32'h1, r);
        cyc(4);
        chk(out_drive_en, 0);
        rd(`REG_CTRL, d, r);
        chk(d, 32'h1);
        wr(`REG_CTRL, 32'h0, r);
        wait_on(2'b11);
        chk(out_drive_en, 2'b11);
        for (i = 0; i < 2; i++) begin
            @(posedge aclk);
            oc <= (i == 0);
            ot <= (i == 1);
            cyc(8);
            chk(fault_flag_out, 0);
            chk(out_drive_en, 0);
            chk(irq, 1);
            @(posedge aclk);
            oc <= 1'b0;
            ot <= 1'b0;
            cyc(10);
            chk(fault_flag_out, 0);
            rd(`REG_IRQ_STAT, d, r);
            chk(d[i], 1);
            // status re-sets while the fault stays latched, so clear after shutdown
            @(posedge aclk);
            sd_run <= 1'b0;
            cyc(8);
            chk(fault_flag_out, 1);
            wr(`REG_IRQ_CLR, 32'h1 << i, r);
            cyc(2);
            chk(irq, 0);
            @(posedge aclk);
            sd_run <= 1'b1;
            wait_on(2'b11);
            chk(out_drive_en, 2'b11);
        end
        $display("latched fault test done");
        @(posedge aclk);
        al <= 8'h40;
        cyc(30);
        chk(fault_flag_out, 1);
        cyc(400);
        chk(fault_flag_out, 0);
        chk(out_drive_en, 0);
        chk(irq, 1);
        wr(`REG_IRQ_EN, 32'h0, r);
        cyc(2);
        chk(irq, 0);
        @(posedge aclk);
        al <= 8'h00;
        sd_auto <= 1'b1;
        cyc(4);
        wait_on(2'b11);
        chk(out_drive_en, 2'b11);
        $display("dc detect test done");
        @(posedge aclk);
        aresetn <= 1'b0;
        lp <= 1'b1;
        lm <= 1'b1;
        sd_auto <= 1'b0;
        sd_run <= 1'b0;
        ar8 <= 8'h10;
        cyc(4);
        @(posedge aclk);
        aresetn <= 1'b1;
        sd_run <= 1'b1;
        wait_on(2'b11);
        rd(`REG_STATUS, d, r);
        chk(d[7], 1);
        duty(8'h00);
        chk(p > n, 1);
        $display("mono test done");
        report_and_stop;
    end
endmodule // amp_fault_protection_modulation_test
`default_nettype wire
